// File: verilog/can_tx_fifo_defines.vh
`ifndef CAN_TX_FIFO_DEFINES_VH
`define CAN_TX_FIFO_DEFINES_VH
// ----------------------------------------
// Register offsets, word indices within a slot; stride in bytes
// ----------------------------------------
`define FIFO_STRIDE 8'h20
`define OFS_CONFIG 3'h0
`define OFS_STATUS 3'h1
`define OFS_MSG_ID 3'h2
`define OFS_MSG_DATA 3'h3
`define OFS_PTR_CTRL 3'h4
`define GLOBAL_SLOT 2'h3
`define OFS_GLOBAL_CFG 3'h0
`define OFS_CHAN_MODE 3'h1
// ----------------------------------------
// Config word fields
// ----------------------------------------
`define CFG_EN 0
`define CFG_MODE_LO 1
`define CFG_IRQ_MODE 3
`define CFG_TXDONE_IE 4
`define CFG_ONEFRAME_IE 5
`define CFG_RANGE_X10 6
`define CFG_SRC_SEL 7
`define CFG_IVL_LO 8
`define CFG_LINK_LO 16
`define CFG_RESET 32'h00000000
// ----------------------------------------
// Status word fields
// ----------------------------------------
`define STS_EMPTY 0
`define STS_FULL 1
`define STS_TXDONE 2
`define STS_ONEFRAME 3
`define STS_CNT_LO 8
// ----------------------------------------
// Codes and counts
// ----------------------------------------
`define MODE_TX 2'h1
`define PTR_ADVANCE 8'hFF
`define CHAN_MODE_RESET 2'h1
`define PRESCALE_RESET 16'h0001
`define DECADE 4'h9
`define PCLK_HALF 2
`endif

// File: verilog/fifo_interval_timer.v
`timescale 1ns/100ps
`default_nettype none
module fifo_interval_timer #(
  parameter W = 8
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Control
  input wire start,
  input wire stop,
  input wire tick,
  input wire [W-1:0] limit,
  // State
  output wire busy
);

  reg busy_ff;
  reg [W-1:0] cnt_ff;

  assign busy = busy_ff;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_ff <= 1'b0;
      cnt_ff <= {W{1'b0}};
    end else if (stop) begin
      busy_ff <= 1'b0;
      cnt_ff <= {W{1'b0}};
    end else if (start) begin
      busy_ff <= (limit != {W{1'b0}});
      cnt_ff <= {W{1'b0}};
    end else if (busy_ff && tick) begin
      if (cnt_ff + 1'b1 >= limit) begin
        busy_ff <= 1'b0;
        cnt_ff <= {W{1'b0}};
      end else begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// File: verilog/can_tx_fifo_interval.v
// Our own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "can_tx_fifo_defines.vh"

// Summary of operation
// - Three transmit FIFOs per channel, each holding up to 128 messages.
// - Each FIFO sends its messages oldest first, in stored order.
// - A 5-bit link field picks each FIFO's associated transmit buffer.
// - Enabled FIFOs join arbitration with their head message only.
// - Identifier and data writes accepted only in transmit mode.
// - Writing FF to pointer control commits the message, advancing the pointer.
// - Clearing enable discards all messages; empty flag then reads one.
// - Disable during an in-flight frame empties after done, error or loss.
// - Abort raises no interrupt; an in-flight frame may still complete.
// - Interval counter starts at successful completion; expiry releases next.
// - Interval counter stops on disable or channel reset mode.
// - Tick is pclk/2 divided by M or 10M, or the bit clock.
// - Gap between frames is N ticks from the 8-bit interval field.
// - Prescaler not reset on completion; first gap may err one tick.
// - Request presented at once, well under three bit clocks.
// - Done flag sets on empty or per message, gated by its enable.
// - Disable leaves the done flag set; software clears by writing 0.
// - One-frame flag sets per frame when enabled; survives disable.
// - Both flags merge into the single channel transmit interrupt.
module can_tx_fifo_interval #(
  parameter DEPTH = 128,
  parameter AW = 7
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Avalon-MM slave
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  // Protocol engine, same clock
  input wire bit_tick,
  output wire tx_req,
  output wire [31:0] tx_id,
  output wire [31:0] tx_data,
  output wire [4:0] tx_link,
  output wire [1:0] tx_src,
  input wire tx_ack,
  input wire tx_done,
  input wire tx_bus_err,
  input wire tx_arb_lost,
  // Channel transmit interrupt
  output wire tx_irq
);
  localparam NF = 3;
  // ----------------------------------------
  // Byte-lane merge
  // ----------------------------------------
  function [31:0] be_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] be;
    integer b;
    begin
      be_merge = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (be[b]) begin
          be_merge[8*b +: 8] = new_v[8*b +: 8];
        end
      end
    end
  endfunction
  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [31:0] cfg_ff [0:NF-1];
  reg [AW-1:0] wp_ff [0:NF-1];
  reg [AW-1:0] rp_ff [0:NF-1];
  reg [AW:0] cnt_ff [0:NF-1];
  reg [31:0] id_mem [0:NF*DEPTH-1];
  reg [31:0] data_mem [0:NF*DEPTH-1];
  reg [NF-1:0] txdone_ff;
  reg [NF-1:0] oneframe_ff;
  reg [NF-1:0] flush_ff;
  reg [15:0] prescale_ff;
  reg [1:0] chan_mode_ff;
  reg [31:0] rdata_ff;
  reg rvalid_ff;
  reg busy_ff;
  reg [1:0] src_ff;
  reg req_ff;
  reg [1:0] req_src_ff;
  reg [31:0] tx_id_ff;
  reg [31:0] tx_data_ff;
  reg [4:0] tx_link_ff;
  reg [16:0] pre_cnt_ff;
  reg [3:0] dec_cnt_ff;
  wire [1:0] slot = avs_address[6:5];
  wire [2:0] ofs = avs_address[4:2];
  wire map_ok = (avs_address[7] == 1'b0);
  wire wr_go = avs_write && map_ok;
  wire [31:0] pre_wr = be_merge({16'h0000, prescale_ff}, avs_writedata,
    avs_byteenable);
  // ----------------------------------------
  // Avalon handshake
  // ----------------------------------------
  // Reads take one wait state so read data leaves a flip-flop
  assign avs_waitrequest = avs_read && !rvalid_ff;
  assign avs_readdata = rdata_ff;
  // ----------------------------------------
  // Interval prescaler, free running
  // ----------------------------------------
  wire [15:0] m_val = (prescale_ff == 16'h0000) ? 16'h0001 : prescale_ff;
  wire [16:0] pre_top = {m_val, 1'b0} - 17'h00001;
  wire tick_m = (pre_cnt_ff == pre_top);
  wire tick_m10 = tick_m && (dec_cnt_ff == `DECADE);
  // Never cleared by a completion, so the first gap may be short
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre_cnt_ff <= 17'h00000;
      dec_cnt_ff <= 4'h0;
    end else begin
      pre_cnt_ff <= tick_m ? 17'h00000 : pre_cnt_ff + 17'h00001;
      if (tick_m) begin
        dec_cnt_ff <= (dec_cnt_ff == `DECADE) ? 4'h0 : dec_cnt_ff + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // Per-FIFO decode and interval timers
  // ----------------------------------------
  wire [NF-1:0] en;
  wire [NF-1:0] tx_mode;
  wire [NF-1:0] full;
  wire [NF-1:0] empty;
  wire [NF-1:0] ivl_busy;
  wire [NF-1:0] cand;
  wire [NF-1:0] done_k;
  wire [NF-1:0] fail_k;
  wire [NF-1:0] inflight;
  wire ack_ok = tx_req && tx_ack;
  genvar k;
  generate
    for (k = 0; k < NF; k = k + 1) begin : g_fifo
      wire [31:0] c = cfg_ff[k];
      wire tick_sel;
      assign en[k] = c[`CFG_EN];
      assign tx_mode[k] = (c[`CFG_MODE_LO +: 2] == `MODE_TX);
      assign full[k] = (cnt_ff[k] == DEPTH[AW:0]);
      assign empty[k] = (cnt_ff[k] == {(AW+1){1'b0}});
      assign done_k[k] = busy_ff && tx_done && (src_ff == k);
      assign fail_k[k] = busy_ff && (src_ff == k) &&
                         (tx_bus_err || tx_arb_lost);
      assign inflight[k] = (busy_ff && src_ff == k) ||
                           (ack_ok && req_src_ff == k);
      assign tick_sel = c[`CFG_SRC_SEL] ? bit_tick :
                        (c[`CFG_RANGE_X10] ? tick_m10 : tick_m);
      assign cand[k] = en[k] && tx_mode[k] && !empty[k] &&
                       !ivl_busy[k] && !flush_ff[k];
      fifo_interval_timer #(.W(8)) u_ivl (
        .clk(sys_clk),
        .rst(rst),
        .start(done_k[k] && en[k]),
        .stop(!en[k] || chan_mode_ff == `CHAN_MODE_RESET),
        .tick(tick_sel),
        .limit(c[`CFG_IVL_LO +: 8]),
        .busy(ivl_busy[k])
      );
    end
  endgenerate
  // ----------------------------------------
  // Head selection
  // ----------------------------------------
  reg best_v;
  reg [1:0] best_k;
  reg [31:0] best_id;
  integer j;
  always @* begin
    best_v = 1'b0;
    best_k = 2'h0;
    best_id = 32'h00000000;
    for (j = 0; j < NF; j = j + 1) begin
      // Lowest identifier wins; ties go to the lower FIFO
      if (cand[j] && (!best_v ||
          id_mem[j*DEPTH + rp_ff[j]] < best_id)) begin
        best_v = 1'b1;
        best_k = j[1:0];
        best_id = id_mem[j*DEPTH + rp_ff[j]];
      end
    end
  end

  // Request drops at once if its FIFO stops qualifying
  assign tx_req = req_ff && !busy_ff && cand[req_src_ff];
  assign tx_id = tx_id_ff;
  assign tx_data = tx_data_ff;
  assign tx_link = tx_link_ff;
  assign tx_src = req_src_ff;
  assign tx_irq = |txdone_ff || |oneframe_ff;
  // ----------------------------------------
  // Engine handshake
  // ----------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy_ff <= 1'b0;
      src_ff <= 2'h0;
      req_ff <= 1'b0;
      req_src_ff <= 2'h0;
      tx_id_ff <= 32'h00000000;
      tx_data_ff <= 32'h00000000;
      tx_link_ff <= 5'h00;
    end else if (busy_ff) begin
      if (tx_done || tx_bus_err || tx_arb_lost) begin
        busy_ff <= 1'b0;
        req_ff <= 1'b0;
      end
    end else if (ack_ok) begin
      busy_ff <= 1'b1;
      src_ff <= req_src_ff;
    end else begin
      req_ff <= best_v;
      req_src_ff <= best_k;
      tx_id_ff <= best_id;
      tx_data_ff <= data_mem[best_k*DEPTH + rp_ff[best_k]];
      tx_link_ff <= cfg_ff[best_k][`CFG_LINK_LO +: 5];
    end
  end

  // ----------------------------------------
  // Registers, FIFO pointers and flags
  // ----------------------------------------
  integer i;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < NF; i = i + 1) begin
        cfg_ff[i] <= `CFG_RESET;
        wp_ff[i] <= {AW{1'b0}};
        rp_ff[i] <= {AW{1'b0}};
        cnt_ff[i] <= {(AW+1){1'b0}};
      end
      txdone_ff <= {NF{1'b0}};
      oneframe_ff <= {NF{1'b0}};
      flush_ff <= {NF{1'b0}};
      prescale_ff <= `PRESCALE_RESET;
      chan_mode_ff <= `CHAN_MODE_RESET;
    end else begin
      if (wr_go && slot == `GLOBAL_SLOT) begin
        if (ofs == `OFS_GLOBAL_CFG) begin
          prescale_ff <= pre_wr[15:0];
        end
        if (ofs == `OFS_CHAN_MODE && avs_byteenable[0]) begin
          chan_mode_ff <= avs_writedata[1:0];
        end
      end
      for (i = 0; i < NF; i = i + 1) begin
        if (wr_go && slot == i) begin
          case (ofs)
            `OFS_CONFIG: begin
              cfg_ff[i] <= be_merge(cfg_ff[i], avs_writedata,
                                    avs_byteenable);
            end
            `OFS_STATUS: begin
              // Clearing only; software writes 0 to drop a flag
              if (avs_byteenable[0] && !avs_writedata[`STS_TXDONE]) begin
                txdone_ff[i] <= 1'b0;
              end
              if (avs_byteenable[0] && !avs_writedata[`STS_ONEFRAME]) begin
                oneframe_ff[i] <= 1'b0;
              end
            end
            `OFS_MSG_ID: begin
              if (tx_mode[i]) begin
                id_mem[i*DEPTH + wp_ff[i]] <= be_merge(
                  id_mem[i*DEPTH + wp_ff[i]], avs_writedata,
                  avs_byteenable);
              end
            end
            `OFS_MSG_DATA: begin
              if (tx_mode[i]) begin
                data_mem[i*DEPTH + wp_ff[i]] <= be_merge(
                  data_mem[i*DEPTH + wp_ff[i]], avs_writedata,
                  avs_byteenable);
              end
            end
            `OFS_PTR_CTRL: begin
              // Advances while full are dropped
              if (avs_byteenable[0] && tx_mode[i] && en[i] &&
                  !full[i] && !flush_ff[i] &&
                  avs_writedata[7:0] == `PTR_ADVANCE) begin
                wp_ff[i] <= wp_ff[i] + 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
        // Hardware sets after the software clear, so a set wins
        if (done_k[i] && cfg_ff[i][`CFG_TXDONE_IE] &&
            (cfg_ff[i][`CFG_IRQ_MODE] ||
             cnt_ff[i] == {{AW{1'b0}}, 1'b1})) begin
          txdone_ff[i] <= 1'b1;
        end
        if (done_k[i] && cfg_ff[i][`CFG_ONEFRAME_IE]) begin
          oneframe_ff[i] <= 1'b1;
        end
        // Abort: empties now, or once the in-flight frame ends
        if (!en[i] && (!inflight[i] || done_k[i] || fail_k[i])) begin
          wp_ff[i] <= {AW{1'b0}};
          rp_ff[i] <= {AW{1'b0}};
          cnt_ff[i] <= {(AW+1){1'b0}};
          flush_ff[i] <= 1'b0;
        end else begin
          if (!en[i]) begin
            flush_ff[i] <= 1'b1;
          end
          if (done_k[i]) begin
            rp_ff[i] <= rp_ff[i] + 1'b1;
          end
          cnt_ff[i] <= cnt_ff[i] + (wr_go && slot == i &&
            ofs == `OFS_PTR_CTRL && avs_byteenable[0] && tx_mode[i] &&
            en[i] && !full[i] && !flush_ff[i] &&
            avs_writedata[7:0] == `PTR_ADVANCE) - done_k[i];
        end
      end
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    if (map_ok && slot == `GLOBAL_SLOT) begin
      if (ofs == `OFS_GLOBAL_CFG) begin
        rd_mux = {16'h0000, prescale_ff};
      end else if (ofs == `OFS_CHAN_MODE) begin
        rd_mux = {30'h00000000, chan_mode_ff};
      end
    end else if (map_ok && ofs == `OFS_CONFIG) begin
      rd_mux = cfg_ff[slot];
    end else if (map_ok && ofs == `OFS_STATUS) begin
      rd_mux[`STS_EMPTY] = empty[slot];
      rd_mux[`STS_FULL] = full[slot];
      rd_mux[`STS_TXDONE] = txdone_ff[slot];
      rd_mux[`STS_ONEFRAME] = oneframe_ff[slot];
      rd_mux[`STS_CNT_LO +: AW+1] = cnt_ff[slot];
    end
  end
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 32'h00000000;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= avs_read && !rvalid_ff;
      if (avs_read && !rvalid_ff) begin
        rdata_ff <= rd_mux;
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/can_tx_fifo_interval_props.sv
`timescale 1ns/100ps
`default_nettype none
module can_tx_fifo_interval_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  // Engine link
  input wire logic tx_req,
  input wire logic tx_ack,
  input wire logic tx_done,
  input wire logic tx_bus_err,
  input wire logic tx_arb_lost,
  input wire logic [31:0] tx_id,
  input wire logic [31:0] tx_data,
  input wire logic [4:0] tx_link,
  input wire logic tx_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Own copy of the in-flight state, so a stuck busy shows
  logic flight_ff;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flight_ff <= 1'b0;
    end else if (tx_req && tx_ack) begin
      flight_ff <= 1'b1;
    end else if (tx_done || tx_bus_err || tx_arb_lost) begin
      flight_ff <= 1'b0;
    end
  end
  sequence rd_walk;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  rd_wait_a: assert property ($rose(avs_read) |-> rd_walk)
    else $error("read answer timing wrong");
  wr_nowait_a: assert property (avs_write |-> !avs_waitrequest)
    else $error("write was stalled");
  idle_nowait_a: assert property (!avs_read |-> !avs_waitrequest)
    else $error("wait without a read");
  rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  one_flight_a: assert property (flight_ff |-> !tx_req)
    else $error("request while a frame is in flight");
  flight_frozen_a: assert property (flight_ff && $past(flight_ff) |->
    $stable(tx_id) && $stable(tx_data) && $stable(tx_link))
    else $error("head message changed in flight");
  done_gap_a: assert property (tx_done |=> !tx_req)
    else $error("request right after completion");
  irq_cause_a: assert property ($rose(tx_irq) |-> $past(tx_done))
    else $error("interrupt without a completed frame");
  irq_sticky_a: assert property ($fell(tx_irq) |-> $past(avs_write))
    else $error("interrupt dropped without a clear");
endmodule
bind can_tx_fifo_interval can_tx_fifo_interval_props props_u (
  .sys_clk(sys_clk), .rst(rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .avs_readdata(avs_readdata), .tx_req(tx_req), .tx_ack(tx_ack),
  .tx_done(tx_done), .tx_bus_err(tx_bus_err), .tx_arb_lost(tx_arb_lost),
  .tx_id(tx_id), .tx_data(tx_data), .tx_link(tx_link), .tx_irq(tx_irq));
`default_nettype wire

// File: testbench/can_engine_model.sv
`timescale 1ns/100ps
`default_nettype none
module can_engine_model #(
  parameter TICK = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Bench control
  input wire logic hold,
  input wire logic [1:0] fail,
  input wire logic [7:0] frame_len,
  // Link to the block
  input wire logic tx_req,
  output logic bit_tick,
  output logic tx_ack,
  output logic tx_done,
  output logic tx_bus_err,
  output logic tx_arb_lost
);
  logic [3:0] div_ff;
  logic [7:0] left_ff;
  logic busy_ff;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_ff <= 4'h0;
      left_ff <= 8'h00;
      busy_ff <= 1'b0;
      {bit_tick, tx_ack, tx_done, tx_bus_err, tx_arb_lost} <= 5'h00;
    end else begin
      div_ff <= (div_ff == TICK - 1) ? 4'h0 : div_ff + 4'h1;
      bit_tick <= (div_ff == TICK - 1);
      {tx_ack, tx_done, tx_bus_err, tx_arb_lost} <= 4'h0;
      // Hold lets a queue fill up before anything is taken
      if (!busy_ff && tx_req && !hold) begin
        tx_ack <= 1'b1;
        busy_ff <= 1'b1;
        left_ff <= frame_len;
      end else if (busy_ff && left_ff == 8'h00) begin
        busy_ff <= 1'b0;
        tx_done <= (fail == 2'h0);
        tx_bus_err <= (fail == 2'h1);
        tx_arb_lost <= (fail == 2'h2);
      end else if (busy_ff) begin
        left_ff <= left_ff - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/can_tx_fifo_interval_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define chk(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  mismatches++; $display("mismatch %s exp %h got %h", n, e, g); end end
module can_tx_fifo_interval_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, tx_id, tx_data, st, dt;
  logic avs_waitrequest, bit_tick, tx_req, tx_ack, tx_done;
  logic tx_bus_err, tx_arb_lost, tx_irq;
  logic [4:0] tx_link, lk;
  logic [1:0] tx_src, sr;
  logic [1:0] fail_sel = 2'h0;
  logic hold = 1'b1;
  logic [7:0] frame_len = 8'h0A;
  int mismatches = 0;
  int num_checks = 0;
  int cyc = 0;
  int t_done = 0;
  int gap = 0;
  logic [31:0] ids[$];
  // ----------------------------------------
  // Clock, design and far side
  // ----------------------------------------
  always #25 sys_clk = ~sys_clk;
  can_tx_fifo_interval #(.DEPTH(4), .AW(2)) dut_u (.sys_clk(sys_clk),
    .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .bit_tick(bit_tick),
    .tx_req(tx_req), .tx_id(tx_id), .tx_data(tx_data), .tx_link(tx_link),
    .tx_src(tx_src), .tx_ack(tx_ack), .tx_done(tx_done),
    .tx_bus_err(tx_bus_err), .tx_arb_lost(tx_arb_lost), .tx_irq(tx_irq));
  can_engine_model #(.TICK(4)) eng_u (.sys_clk(sys_clk), .rst(rst),
    .hold(hold), .fail(fail_sel), .frame_len(frame_len), .tx_req(tx_req),
    .bit_tick(bit_tick), .tx_ack(tx_ack), .tx_done(tx_done),
    .tx_bus_err(tx_bus_err), .tx_arb_lost(tx_arb_lost));
  // Mid-cycle sampling keeps clear of edge races
  always @(negedge sys_clk) begin
    cyc++;
    if (tx_done === 1'b1) t_done = cyc;
    if (tx_req === 1'b1 && tx_ack === 1'b1) begin
      ids.push_back(tx_id);
      lk = tx_link;
      dt = tx_data;
      sr = tx_src;
      gap = cyc - t_done;
    end
  end
  // ----------------------------------------
  // Bus and helper tasks
  // ----------------------------------------
  task wr(input [7:0] a, input [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task rd(input [7:0] a, output [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task push(input [1:0] k, input [31:0] id);
    wr({1'b0, k, 5'h08}, id);
    wr({1'b0, k, 5'h0C}, ~id);
    wr({1'b0, k, 5'h10}, 32'h000000FF);
  endtask
  task wait_n(input int n);
    for (int i = 0; i < 3000 && ids.size() < n; i++) @(posedge sys_clk);
    @(posedge sys_clk);
  endtask
  task wait_done;
    for (int i = 0; i < 3000 && tx_done !== 1'b1 &&
         tx_bus_err !== 1'b1 && tx_arb_lost !== 1'b1; i++)
      @(negedge sys_clk);
    @(posedge sys_clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    rd(8'h04, st);
    `chk("status_reset", 32'h00000001, st)
    rd(8'h9C, st);
    `chk("unmapped_read", 32'h00000000, st)
    wr(8'h64, 32'h0);
  endtask
  task t_order;
    wr(8'h00, 32'h00130032);
    push(0, 32'h0AA);
    rd(8'h04, st);
    `chk("commit_disabled", 32'h00000001, st)
    wr(8'h00, 32'h00130033);
    for (int i = 0; i < 3; i++) push(0, 32'h101 + i);
    rd(8'h04, st);
    `chk("count_three", 32'h00000300, st)
    ids.delete();
    hold <= 1'b0;
    wait_n(3);
    wait_done();
    for (int i = 0; i < 3; i++) `chk("order", 32'h101 + i, ids[i])
    `chk("link", 5'h13, lk)
    `chk("data", 32'hFFFFFEFC, dt)
    rd(8'h04, st);
    `chk("flags_set", 32'h0000000D, st)
    `chk("irq_up", 1'b1, tx_irq)
    wr(8'h04, 32'h0);
    rd(8'h04, st);
    `chk("flags_clear", 32'h00000001, st)
    `chk("irq_down", 1'b0, tx_irq)
  endtask
  task t_full;
    hold <= 1'b1;
    wr(8'h20, 32'h00000003);
    for (int i = 0; i < 5; i++) push(1, 32'h300 + i);
    rd(8'h24, st);
    `chk("full_at_depth", 32'h00000402, st)
    wr(8'h20, 32'h00000002);
    rd(8'h24, st);
    `chk("abort_empty", 32'h00000001, st)
    `chk("abort_no_irq", 1'b0, tx_irq)
  endtask
  task t_abort;
    ids.delete();
    frame_len <= 8'h28;
    hold <= 1'b0;
    wr(8'h40, 32'h00000013);
    push(2, 32'h401);
    push(2, 32'h402);
    wait_n(1);
    wr(8'h40, 32'h00000012);
    rd(8'h44, st);
    `chk("flight_kept", 32'h00000200, st & 32'hFFFFFF03)
    wait_done();
    rd(8'h44, st);
    `chk("empty_after", 32'h00000001, st & 32'hFFFFFFFB)
    `chk("one_sent", 1, ids.size())
    wr(8'h44, 32'h0);
    frame_len <= 8'h0A;
  endtask
  // Lost arbitration keeps the head; per-message done flag mode
  task t_retry;
    ids.delete();
    fail_sel <= 2'h2;
    wr(8'h20, 32'h0000001B);
    push(1, 32'h501);
    wait_n(1);
    wait_done();
    fail_sel <= 2'h0;
    push(1, 32'h502);
    wait_n(3);
    wait_done();
    `chk("retry_head", 32'h501, ids[1])
    `chk("retry_next", 32'h502, ids[2])
    `chk("src", 2'h1, sr)
    rd(8'h24, st);
    `chk("per_msg_flag", 32'h00000005, st)
    wr(8'h24, 32'h0);
    wr(8'h20, 32'h0000001A);
  endtask
  task t_ivl(input [31:0] bits, input [31:0] m, input int p);
    hold <= 1'b1;
    wr(8'h60, m);
    wr(8'h00, 32'h00000303 | bits);
    push(0, 32'h2AA);
    push(0, 32'h2AB);
    ids.delete();
    hold <= 1'b0;
    wait_n(2);
    // Prescaler runs free, so one tick of slack below and three cycles above
    `chk("gap", 1'b1, gap > 2 * p + 2 && gap <= 3 * p + 3)
    `chk("second_id", 32'h2AB, ids[1])
    wait_done();
    wr(8'h00, 32'h00000002);
  endtask
  // ----------------------------------------
  // Sequence and verdict
  // ----------------------------------------
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_order();
    t_full();
    t_abort();
    t_retry();
    t_ivl(32'h80, 32'h1, 4);
    t_ivl(32'h00, 32'h3, 6);
    t_ivl(32'h40, 32'h1, 20);
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    wrap_up();
  end
endmodule
`default_nettype wire
